// >>> core/sicc_pkg.sv
// shared constants and types for the stepper indexer and current chopper
package sicc_pkg;

  // step mode codes, numbered in order from full step to 1/32 step
  typedef enum logic [2:0] {
    SICC_FULL,
    SICC_HALF,
    SICC_QUARTER,
    SICC_EIGHTH,
    SICC_SIXTEENTH,
    SICC_THIRTYSECOND
  } sicc_mode_type;

  // tri-level input encoding: 00 low, 01 high, 1x open
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] TRI_OPEN = 2'h2;

  typedef enum logic [1:0] {
    SICC_DECAY_SLOW,
    SICC_DECAY_FAST,
    SICC_DECAY_MIXED
  } sicc_decay_type;

  // bridge drive codes on the output pins
  localparam logic [1:0] BR_OFF   = 2'h0;
  localparam logic [1:0] BR_FWD   = 2'h1;
  localparam logic [1:0] BR_REV   = 2'h2;
  localparam logic [1:0] BR_BRAKE = 2'h3;

  // 128 microstates per electrical turn, home at 45 degrees
  localparam int          IDX_W    = 7;
  localparam logic [6:0]  IDX_HOME = 7'h10;
  localparam int          AMP_W    = 8;

  // chopper timing at 250 MHz
  localparam int REF_CLK_MHZ     = 250;
  localparam int CHOP_PERIOD_NS  = 50000;
  localparam int BLANK_NS        = 2000;
  localparam int MIXED_FAST_NS   = 18750;
  localparam int CHOP_CYCLES     = CHOP_PERIOD_NS * REF_CLK_MHZ / 1000;
  localparam int BLANK_CYCLES    = (BLANK_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int MIXED_CYCLES    = MIXED_FAST_NS * REF_CLK_MHZ / 1000;

  // status / mask bit positions
  localparam int ST_TRIP_A = 0;
  localparam int ST_TRIP_B = 1;
  localparam int ST_STEP   = 2;
  localparam int ST_W      = 3;

  // register indices on the plain register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h1;
  localparam logic [3:0] REG_INDEX  = 4'h2;

endpackage : sicc_pkg

// >>> core/sicc_stepper_indexer.sv
// indexer, two choppers and status registers of a dual bridge motor driver
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

// Operation
// - indexer mode: each rising step edge advances one table state
// - direction input picks forward or reverse walk through the table
// - resolutions from full step down to 1/32 step
// - mode decode 00 full,01 half,0Z quarter,10 eighth,11 sixteenth,1Z 1/32
// - mode sampled at each step edge; moves to next valid state of it
// - indexer returns to 45 degree home after reset or leaving sleep
// - sleep low disables bridges, resets logic, ignores all inputs
// - phase/enable, hi pin low: enable pin pwm, slow decay while off
// - phase/enable, hi pin high: enable low puts winding off
// - sense above trip threshold flags overcurrent on that bridge
// - fixed period chop: after trip, decay until period ends
// - slow, fast and mixed decay per winding
// - decay select low slow, high fast, open mixed; may change anytime
// - blanking at drive start ignores trip; sets minimum drive time
// - phase/enable: phase sets polarity, own reference sets magnitude
module sicc_stepper_indexer #(
  parameter int CHOP_LEN  = sicc_pkg::CHOP_CYCLES,
  parameter int BLANK_LEN = sicc_pkg::BLANK_CYCLES,
  parameter int MIXED_LEN = sicc_pkg::MIXED_CYCLES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       sleep_n_in,
  input  wire logic                       indexer_mode,
  input  wire logic                       step_in,
  input  wire logic                       dir_in,
  input  wire logic [1:0]                 step_mode_sel_lo,
  input  wire logic                       step_mode_sel_hi,
  input  wire logic                       phase_a_in,
  input  wire logic                       phase_b_in,
  input  wire logic                       bridge_enable_a,
  input  wire logic                       bridge_enable_b,
  input  wire logic [1:0]                 decay_sel_a,
  input  wire logic [1:0]                 decay_sel_b,
  input  wire logic                       sense_node_a,
  input  wire logic                       sense_node_b,
  input  wire logic [sicc_pkg::AMP_W-1:0] current_ref_a,
  input  wire logic [sicc_pkg::AMP_W-1:0] current_ref_b,
  input  wire logic [3:0]                 regAddr,
  input  wire logic [31:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [31:0]                regRdata,
  output logic      [1:0]                 bridgeA,
  output logic      [1:0]                 bridgeB,
  output logic                            negA,
  output logic                            negB,
  output logic      [sicc_pkg::AMP_W-1:0] levelA,
  output logic      [sicc_pkg::AMP_W-1:0] levelB,
  output logic                            tripA,
  output logic                            tripB,
  output logic                            irq
);
  import sicc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // quarter-wave sine table, 33 points, 255 = 100 %
  function automatic logic [AMP_W-1:0] sineAt(input logic [5:0] i);
    logic [AMP_W-1:0] s;
    s = 8'h00;
    case (i)
      6'd0:  s = 8'h00; 6'd1:  s = 8'h0D; 6'd2:  s = 8'h19; 6'd3:  s = 8'h26;
      6'd4:  s = 8'h32; 6'd5:  s = 8'h3E; 6'd6:  s = 8'h4A; 6'd7:  s = 8'h56;
      6'd8:  s = 8'h62; 6'd9:  s = 8'h6D; 6'd10: s = 8'h78; 6'd11: s = 8'h83;
      6'd12: s = 8'h8E; 6'd13: s = 8'h98; 6'd14: s = 8'hA2; 6'd15: s = 8'hAB;
      6'd16: s = 8'hB4; 6'd17: s = 8'hBD; 6'd18: s = 8'hC5; 6'd19: s = 8'hCC;
      6'd20: s = 8'hD4; 6'd21: s = 8'hDA; 6'd22: s = 8'hE0; 6'd23: s = 8'hE6;
      6'd24: s = 8'hEB; 6'd25: s = 8'hEF; 6'd26: s = 8'hF3; 6'd27: s = 8'hF6;
      6'd28: s = 8'hF9; 6'd29: s = 8'hFB; 6'd30: s = 8'hFD; 6'd31: s = 8'hFE;
      6'd32: s = 8'hFF;
      default: s = 8'hFF;
    endcase
    return s;
  endfunction : sineAt

  // signed current of winding A at index i (cosine), B is i shifted back 32
  function automatic logic [AMP_W:0] windingAt(input logic [IDX_W-1:0] i);
    logic [5:0] q;
    logic       neg;
    q   = 6'h00;
    neg = 1'b0;
    case (i[6:5])
      2'h0: begin q = 6'd32 - {1'b0, i[4:0]}; neg = 1'b0; end
      2'h1: begin q = {1'b0, i[4:0]}; neg = 1'b1; end
      2'h2: begin q = 6'd32 - {1'b0, i[4:0]}; neg = 1'b1; end
      default: begin q = {1'b0, i[4:0]}; neg = 1'b0; end
    endcase
    return {neg && sineAt(q) != 8'h00, sineAt(q)};
  endfunction : windingAt

  function automatic sicc_decay_type decodeDecay(input logic [1:0] p);
    sicc_decay_type d;
    d = SICC_DECAY_MIXED;
    if (p == TRI_LOW) d = SICC_DECAY_SLOW;
    else if (p == TRI_HIGH) d = SICC_DECAY_FAST;
    return d;
  endfunction : decodeDecay

  ////////////////////////////////////////////////////////////////////////////
  // sleep acts as a second synchronous reset
  wire logic hold = rst || !sleep_n_in;

  logic            stepPrev;
  logic [IDX_W-1:0] index;
  wire logic       stepRise = step_in && !stepPrev;

  wire sicc_mode_type modeNow =
      !step_mode_sel_hi ?
        (step_mode_sel_lo == TRI_LOW  ? SICC_FULL :
         step_mode_sel_lo == TRI_HIGH ? SICC_HALF : SICC_QUARTER) :
        (step_mode_sel_lo == TRI_LOW  ? SICC_EIGHTH :
         step_mode_sel_lo == TRI_HIGH ? SICC_SIXTEENTH
                                      : SICC_THIRTYSECOND);

  // grid spacing in 1/32 microstates; full step sits on odd 45 degree points
  wire logic [IDX_W-1:0] stride =
      modeNow == SICC_FULL    ? 7'h20 : modeNow == SICC_HALF ? 7'h10 :
      modeNow == SICC_QUARTER ? 7'h08 : modeNow == SICC_EIGHTH ? 7'h04 :
      modeNow == SICC_SIXTEENTH ? 7'h02 : 7'h01;
  wire logic [IDX_W-1:0] gridOff = modeNow == SICC_FULL ? IDX_HOME : 7'h00;
  wire logic [IDX_W-1:0] rel     = index - gridOff;
  wire logic [IDX_W-1:0] below   = rel & ~(stride - 7'h01);
  wire logic             onGrid  = below == rel;
  // off-grid forward goes to next point above, reverse to the one below
  wire logic [IDX_W-1:0] fwdRel  = below + stride;
  wire logic [IDX_W-1:0] revRel  = onGrid ? below - stride : below;
  wire logic [IDX_W-1:0] next_index =
      (dir_in ? fwdRel : revRel) + gridOff;

  always_ff @(posedge ref_clk) begin
    if (hold) begin
      stepPrev <= 1'b0;
      index    <= IDX_HOME;
    end else begin
      stepPrev <= step_in;
      if (indexer_mode && stepRise) index <= next_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per winding target: indexer table or phase plus own reference
  wire logic [AMP_W:0] tabA = windingAt(index);
  wire logic [AMP_W:0] tabB = windingAt(index - 7'h20);
  wire logic           polA = indexer_mode ? tabA[AMP_W] : !phase_a_in;
  wire logic           polB = indexer_mode ? tabB[AMP_W] : !phase_b_in;
  wire logic [AMP_W-1:0] magA =
      indexer_mode ? tabA[AMP_W-1:0] : current_ref_a;
  wire logic [AMP_W-1:0] magB =
      indexer_mode ? tabB[AMP_W-1:0] : current_ref_b;
  wire logic enA = indexer_mode || bridge_enable_a;
  wire logic enB = indexer_mode || bridge_enable_b;
  wire logic offMode = !indexer_mode && step_mode_sel_hi;

  ////////////////////////////////////////////////////////////////////////////
  // two choppers, one counter each
  logic [31:0] chopCnt [2];
  logic        decaying [2];
  logic [1:0]  drive [2];
  wire logic   senseIn [2];
  wire logic   enIn [2];
  wire logic   polIn [2];
  wire logic [1:0] decaySel [2];
  assign senseIn[0] = sense_node_a;
  assign senseIn[1] = sense_node_b;
  assign enIn[0]    = enA;
  assign enIn[1]    = enB;
  assign polIn[0]   = polA;
  assign polIn[1]   = polB;
  assign decaySel[0] = decay_sel_a;
  assign decaySel[1] = decay_sel_b;

  for (genvar w = 0; w < 2; w++) begin : gChop
    wire logic blanked  = chopCnt[w] < 32'(BLANK_LEN);
    wire logic trip     = senseIn[w] && !blanked && !decaying[w];
    wire logic periodEnd = chopCnt[w] >= 32'(CHOP_LEN - 1);
    wire sicc_decay_type dmode = decodeDecay(decaySel[w]);
    wire logic fastNow = dmode == SICC_DECAY_FAST ||
        (dmode == SICC_DECAY_MIXED && chopCnt[w] < 32'(MIXED_LEN));
    wire logic [1:0] fwdCode = polIn[w] ? BR_REV : BR_FWD;
    wire logic [1:0] fastCode = polIn[w] ? BR_FWD : BR_REV;

    always_ff @(posedge ref_clk) begin
      if (hold) begin
        chopCnt[w]  <= 32'h0000_0000;
        decaying[w] <= 1'b0;
      end else if (!enIn[w]) begin
        chopCnt[w]  <= 32'h0000_0000;
        decaying[w] <= 1'b0;
      end else if (periodEnd) begin
        chopCnt[w]  <= 32'h0000_0000;
        decaying[w] <= 1'b0;
      end else begin
        chopCnt[w] <= chopCnt[w] + 32'h0000_0001;
        if (trip) decaying[w] <= 1'b1;
      end
    end

    always_comb begin
      if (!enIn[w]) drive[w] = offMode ? BR_OFF : BR_BRAKE;
      else if (!decaying[w]) drive[w] = fwdCode;
      else if (fastNow) drive[w] = fastCode;
      else drive[w] = BR_BRAKE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs registered; sleep forces bridges off
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  wire logic [ST_W-1:0] events = {indexer_mode && stepRise,
      gChop[1].trip, gChop[0].trip};

  always_ff @(posedge ref_clk) begin
    if (hold) begin
      bridgeA <= BR_OFF;
      bridgeB <= BR_OFF;
      negA    <= 1'b0;
      negB    <= 1'b0;
      levelA  <= 8'h00;
      levelB  <= 8'h00;
      tripA   <= 1'b0;
      tripB   <= 1'b0;
    end else begin
      bridgeA <= drive[0];
      bridgeB <= drive[1];
      negA    <= polA;
      negB    <= polB;
      levelA  <= magA;
      levelB  <= magB;
      tripA   <= gChop[0].trip;
      tripB   <= gChop[1].trip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: status write-one-to-clear, set wins over clear
  wire logic wrStatus = regWrite && regAddr == REG_STATUS;
  wire logic wrMask   = regWrite && regAddr == REG_MASK;
  wire logic [31:0] readMux =
      regAddr == REG_STATUS ? {29'h0, status} :
      regAddr == REG_MASK   ? {29'h0, mask} :
      regAddr == REG_INDEX  ? {25'h0, index} : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (hold) begin
      status   <= 3'h0;
      mask     <= 3'h0;
      regRdata <= 32'h0000_0000;
    end else begin
      status <= (status & ~(wrStatus ? regWdata[ST_W-1:0] : 3'h0)) | events;
      if (wrMask) mask <= regWdata[ST_W-1:0];
      regRdata <= regRead ? readMux : 32'h0000_0000;
    end
  end

  assign irq = |(status & mask);

endmodule : sicc_stepper_indexer

// >>> sim/sicc_chk.sv
// port assertions for the indexer and chopper
`timescale 1ns/1ps
module sicc_chk #(
  parameter int BLANK_LEN = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       sleep_n_in,
  input wire logic                       indexer_mode,
  input wire logic                       step_mode_sel_hi,
  input wire logic                       phase_a_in,
  input wire logic                       bridge_enable_a,
  input wire logic [1:0]                 decay_sel_a,
  input wire logic                       sense_node_a,
  input wire logic [sicc_pkg::AMP_W-1:0] current_ref_a,
  input wire logic [1:0]                 bridgeA,
  input wire logic                       negA,
  input wire logic [sicc_pkg::AMP_W-1:0] levelA,
  input wire logic                       tripA
);
  import sicc_pkg::*;
  logic [7:0] sinceEn;
  wire        peOn = sleep_n_in && !indexer_mode;
  // saturating, so a long drive never wraps into a false blanking window
  always_ff @(posedge ref_clk) begin
    if (rst || !bridge_enable_a) sinceEn <= 8'h00;
    else if (sinceEn != 8'hFF) sinceEn <= sinceEn + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence offReq;
    peOn && step_mode_sel_hi && !bridge_enable_a;
  endsequence
  sequence brakeReq;
    peOn && !step_mode_sel_hi && !bridge_enable_a;
  endsequence
  sequence refHeld;
    peOn && bridge_enable_a && $stable(current_ref_a) && $stable(phase_a_in);
  endsequence
  sleep_off_a: assert property (!sleep_n_in |=> bridgeA == BR_OFF
    && levelA == 8'h00 && !negA) else $error("outputs live in sleep");
  pe_off_a: assert property (offReq [*3] |-> bridgeA == BR_OFF)
    else $error("winding not off");
  pe_brake_a: assert property (brakeReq [*3] |-> bridgeA == BR_BRAKE)
    else $error("winding not braked");
  ref_level_a: assert property (refHeld [*3] |-> levelA == current_ref_a
    && negA == !phase_a_in) else $error("level or polarity wrong");
  trip_blank_a: assert property (tripA && peOn |-> sinceEn >= BLANK_LEN)
    else $error("trip inside blanking");
  trip_cause_a: assert property (tripA |-> $past(sense_node_a)
    || $past(sense_node_a, 2)) else $error("trip without sense");
  no_trip_a: assert property (!sense_node_a [*3] |-> !tripA)
    else $error("trip with sense low");
  slow_decay_a: assert property (tripA && peOn && bridge_enable_a
    && decay_sel_a == TRI_LOW |-> ##[0:2] bridgeA == BR_BRAKE)
    else $error("slow decay missing");
endmodule : sicc_chk

bind sicc_stepper_indexer sicc_chk #(.BLANK_LEN(BLANK_LEN)) chk (
  .ref_clk(ref_clk), .rst(rst), .sleep_n_in(sleep_n_in),
  .indexer_mode(indexer_mode), .step_mode_sel_hi(step_mode_sel_hi),
  .phase_a_in(phase_a_in), .bridge_enable_a(bridge_enable_a),
  .decay_sel_a(decay_sel_a), .sense_node_a(sense_node_a),
  .current_ref_a(current_ref_a), .bridgeA(bridgeA), .negA(negA),
  .levelA(levelA), .tripA(tripA));

// >>> sim/sicc_host_model.sv
// host side model: step pulse source with optional ramp
`timescale 1ns/1ps
module sicc_host_model (
  input  wire logic ref_clk,
  output logic      step_in
);
  initial step_in = 1'b0;
  // square wave of half period h; ramp shortens h pulse by pulse
  task automatic pulse(input int n, input int half, input bit ramp);
    int h;
    h = half;
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk) step_in <= 1'b1;
      repeat (h) @(posedge ref_clk);
      step_in <= 1'b0;
      repeat (h - 1) @(posedge ref_clk);
      if (ramp && h > 1) h = h - 1;
    end
    @(posedge ref_clk);
  endtask : pulse
endmodule : sicc_host_model

// >>> sim/stepper_indexer_current_chopper_tb_top.sv
// self-checking bench for the indexer and chopper
`timescale 1ns/1ps
module stepper_indexer_current_chopper_tb_top;
  import sicc_pkg::*;
  localparam int CHOP  = 40;
  localparam int BLANK = 4;
  logic        refClk = 1'b0;
  logic        rst = 1'b1;
  logic        sleepN = 1'b1;
  logic        idxMode = 1'b1;
  logic        dir = 1'b1;
  logic [1:0]  selLo = TRI_LOW;
  logic        selHi = 1'b0;
  logic        phA = 1'b1;
  logic        enA = 1'b0;
  logic [1:0]  decA = TRI_LOW;
  logic        senseA = 1'b0;
  logic [7:0]  refA = 8'h00;
  logic [3:0]  rAddr = 4'h0;
  logic [31:0] rWdata = 32'h0;
  logic        rWr = 1'b0;
  logic        rRd = 1'b0;
  logic [31:0] rData;
  logic        stepIn, negA, trA, irq;
  logic [1:0]  brA, brB;
  logic        ngB, trB;
  logic [7:0]  lvA, lvB;
  int          failCount = 0;
  int          compares = 0;
  int          n;
  // {hi, lo, dir, index after one step}
  logic [11:0] walk [10] = '{12'hD11, 12'h130, 12'h340, 12'h438, 12'h834,
                             12'hB36, 12'h030, 12'h010, 12'h070, 12'h110};
  always #2 refClk = ~refClk;
  sicc_host_model host (.ref_clk(refClk), .step_in(stepIn));
  sicc_stepper_indexer #(.CHOP_LEN(CHOP), .BLANK_LEN(BLANK), .MIXED_LEN(15)) DUT (
    .ref_clk(refClk), .rst(rst), .sleep_n_in(sleepN), .indexer_mode(idxMode),
    .step_in(stepIn), .dir_in(dir), .step_mode_sel_lo(selLo),
    .step_mode_sel_hi(selHi), .phase_a_in(phA), .phase_b_in(phA),
    .bridge_enable_a(enA), .bridge_enable_b(enA), .decay_sel_a(decA),
    .decay_sel_b(decA), .sense_node_a(senseA), .sense_node_b(senseA),
    .current_ref_a(refA), .current_ref_b(refA), .regAddr(rAddr),
    .regWdata(rWdata), .regWrite(rWr), .regRead(rRd), .regRdata(rData),
    .bridgeA(brA), .bridgeB(brB), .negA(negA), .negB(ngB), .levelA(lvA),
    .levelB(lvB), .tripA(trA), .tripB(trB), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wt(input int k);
    repeat (k) @(posedge refClk);
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wt(1);
    rAddr <= a;
    rWdata <= d;
    rWr <= 1'b1;
    wt(1);
    rWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wt(1);
    rAddr <= a;
    rRd <= 1'b1;
    wt(1);
    rRd <= 1'b0;
    #1 check(rData, e);
  endtask : rd
  task automatic endOfTest;
    $display("compares %0d failures %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : endOfTest
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge refClk);
    failCount++;
    endOfTest;
  end
  initial begin
    wt(6);
    rst <= 1'b0;
    rd(REG_INDEX, 32'h10);
    rd(4'h3, 32'h0);
    wr(REG_MASK, 32'h4);
    foreach (walk[i]) begin
      selHi <= walk[i][11];
      selLo <= walk[i][10:9];
      dir <= walk[i][8];
      host.pulse(1, 2, 1'b0);
      rd(REG_INDEX, {24'h0, walk[i][7:0]});
      if (i == 2) check({negA, lvA, lvB}, 17'h1FF00);
      check(irq, 1'b1);
      wr(REG_STATUS, 32'h4);
      #1 check(irq, 1'b0);
    end
    idxMode <= 1'b0;
    host.pulse(3, 3, 1'b1);
    rd(REG_INDEX, 32'h10);
    wt(1);
    selHi <= 1'b1;
    wt(4);
    #1 check(brA, BR_OFF);
    wt(1);
    selHi <= 1'b0;
    wt(4);
    #1 check(brA, BR_BRAKE);
    wt(1);
    enA <= 1'b1;
    refA <= 8'h5A;
    wt(4);
    #1 check({negA, lvA}, 9'h05A);
    wt(1);
    phA <= 1'b0;
    wt(4);
    n = 0;
    repeat (2 * CHOP) @(negedge refClk) if (brA !== BR_REV) n++;
    check(n, 0);
    check({negA, lvA}, 9'h15A);
    check({ngB, brB}, {1'b1, BR_REV});
    for (int d = 0; d < 3; d++) begin
      wt(1);
      enA <= 1'b0;
      phA <= 1'b1;
      decA <= d[1:0];
      wt(2);
      enA <= 1'b1;
      senseA <= 1'b1;
      n = 0;
      while (trA !== 1'b1 && n < 50) begin
        @(negedge refClk);
        n++;
      end
      check(n >= BLANK && n <= BLANK + 4, 1'b1);
      check(trB, 1'b1);
      @(posedge refClk) senseA <= 1'b0;
      @(negedge refClk);
      check(brA !== BR_FWD, 1'b1);
      if (d == 0) check(brA, BR_BRAKE);
      n = 0;
      while (brA !== BR_FWD && n < 2 * CHOP) begin
        @(negedge refClk);
        n++;
      end
      check(n < CHOP, 1'b1);
    end
    rd(REG_STATUS, 32'h3);
    wr(REG_MASK, 32'h3);
    #1 check(irq, 1'b1);
    wr(REG_STATUS, 32'h3);
    #1 check(irq, 1'b0);
    idxMode <= 1'b1;
    selHi <= 1'b1;
    selLo <= TRI_OPEN;
    dir <= 1'b1;
    host.pulse(3, 1, 1'b0);
    rd(REG_INDEX, 32'h13);
    wt(1);
    sleepN <= 1'b0;
    wt(2);
    #1 check(brA, BR_OFF);
    wt(1);
    sleepN <= 1'b1;
    rd(REG_INDEX, 32'h10);
    rd(REG_MASK, 32'h0);
    endOfTest;
  end
endmodule : stepper_indexer_current_chopper_tb_top
